//--- shared/cafm_defines.svh
`ifndef CAFM_DEFINES_SVH
`define CAFM_DEFINES_SVH
// register byte addresses on the special function register port
`define CAFM_ADDR_TPRESC   8'hA1
`define CAFM_ADDR_MSGWIN   8'hA3
`define CAFM_ADDR_PAGE     8'hB1
`define CAFM_ADDR_TAG1     8'hBC
`define CAFM_ADDR_TAG2     8'hBD
`define CAFM_ADDR_TAG3     8'hBE
`define CAFM_ADDR_TAG4     8'hBF
`define CAFM_ADDR_MSK1     8'hC4
`define CAFM_ADDR_MSK2     8'hC5
`define CAFM_ADDR_MSK3     8'hC6
`define CAFM_ADDR_MSK4     8'hC7
// page register fields
`define CAFM_PAGE_OBJ_MSB  7
`define CAFM_PAGE_OBJ_LSB  4
`define CAFM_PAGE_AINC_BIT 3
`define CAFM_PAGE_IDX_MSB  2
// byte 4 field positions
`define CAFM_B4_RTR_BIT    2
`define CAFM_B4_RB1_BIT    1
`define CAFM_B4_IDE_BIT    0
`define CAFM_TPRESC_RST    8'h00
`define CAFM_PAGE_RST      8'h00
`define CAFM_IDX_LAST      3'h7
`endif

//--- shared/cafm_pkg.sv
package cafm_pkg;
   typedef struct packed {
      logic        valid;
      logic        ide;
      logic        rtr;
      logic        rb1;
      logic        rb0;
      logic [28:0] ident;
   } cafm_frame_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cafm_sfr_req_t;
endpackage

//--- src/cafm_filter_mailbox.sv
`timescale 1ns/1ps
`include "cafm_defines.svh"
module cafm_filter_mailbox
   import cafm_pkg::*;
#(
   parameter int NUM_OBJ = 15
) (
   input  wire logic          mclk_in,       // controller clock
   input  wire logic          rst_n_in,      // sync reset, active low
   input  wire cafm_sfr_req_t sfr_in,        // register port request
   output logic [7:0]         sfr_rdata_out, // register read data
   input  wire cafm_frame_t   rx_frame_in,   // received frame header
   input  wire logic [NUM_OBJ-1:0] obj_rx_en_in,  // object set to receive
   input  wire logic [NUM_OBJ-1:0] obj_ext_in,    // object uses 29-bit ids
   output logic [NUM_OBJ-1:0] rx_hit_out,    // per-object hit, registered
   input  wire logic [3:0]    tx_obj_in,     // object being transmitted
   input  wire logic [2:0]    tx_byte_in,    // byte of that object
   output logic [7:0]         tx_byte_out,   // mailbox byte, registered
   output logic [7:0]         tx_tag4_out,   // tag byte 4 of tx object
   output logic [7:0]         timer_prescale_out // prescaler value
);

   ////////////////////////////////////////////////////////////////////////
   // storage: tags, masks and mailboxes carry no reset
   // no reset value
   logic [7:0] tag_mem [NUM_OBJ][4];
   logic [7:0] msk_mem [NUM_OBJ][4];
   logic [7:0] mbox    [NUM_OBJ][8];
   logic [7:0] timer_prescale_value;
   logic [7:0] page;
   logic [7:0] tx_byte_q;
   logic [7:0] tx_tag4_q;
   logic [NUM_OBJ-1:0] hit_q;

   ////////////////////////////////////////////////////////////////////////
   // address decode
   wire logic [3:0] sel_obj = page[`CAFM_PAGE_OBJ_MSB:`CAFM_PAGE_OBJ_LSB];
   wire logic       auto_inc = page[`CAFM_PAGE_AINC_BIT];
   wire logic [2:0] byte_index = page[`CAFM_PAGE_IDX_MSB:0];
   // objects beyond the count are not backed by storage
   wire logic       obj_ok = 32'(sel_obj) < NUM_OBJ;
   wire logic       hit_tpresc = sfr_in.addr == `CAFM_ADDR_TPRESC;
   wire logic       hit_win    = sfr_in.addr == `CAFM_ADDR_MSGWIN;
   wire logic       hit_page   = sfr_in.addr == `CAFM_ADDR_PAGE;
   wire logic       hit_tag    = sfr_in.addr >= `CAFM_ADDR_TAG1 &&
                                 sfr_in.addr <= `CAFM_ADDR_TAG4;
   wire logic       hit_msk    = sfr_in.addr >= `CAFM_ADDR_MSK1 &&
                                 sfr_in.addr <= `CAFM_ADDR_MSK4;
   wire logic [1:0] reg_idx    = sfr_in.addr[1:0];
   wire logic       win_access = hit_win && (sfr_in.wr || sfr_in.rd);

   function automatic logic [2:0] next_index(input logic [2:0] idx);
      return (idx == `CAFM_IDX_LAST) ? 3'h0 : idx + 3'h1;
   endfunction

   logic [7:0] rdata_mux;
   always_comb begin
      rdata_mux = 8'h00;
      if (hit_tpresc) begin
         rdata_mux = timer_prescale_value;
      end else if (hit_page) begin
         rdata_mux = page;
      end else if (hit_win && obj_ok) begin
         rdata_mux = mbox[sel_obj][byte_index];
      // reserved bits read back whatever was stored
      end else if (hit_tag && obj_ok) begin
         rdata_mux = tag_mem[sel_obj][reg_idx];
      end else if (hit_msk && obj_ok) begin
         rdata_mux = msk_mem[sel_obj][reg_idx];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register port
   always_ff @(posedge mclk_in) begin
      if (sfr_in.wr && obj_ok) begin
         if (hit_win) begin
            mbox[sel_obj][byte_index] <= sfr_in.wdata;
         end
         if (hit_tag) begin
            tag_mem[sel_obj][reg_idx] <= sfr_in.wdata;
         end
         if (hit_msk) begin
            msk_mem[sel_obj][reg_idx] <= sfr_in.wdata;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         timer_prescale_value <= `CAFM_TPRESC_RST;
         page                 <= `CAFM_PAGE_RST;
         sfr_rdata_out        <= 8'h00;
      end else begin
         sfr_rdata_out <= sfr_in.rd ? rdata_mux : 8'h00;
         if (sfr_in.wr && hit_tpresc) begin
            timer_prescale_value <= sfr_in.wdata;
         end
         if (sfr_in.wr && hit_page) begin
            page <= sfr_in.wdata;
         end else if (win_access && auto_inc) begin
            page[`CAFM_PAGE_IDX_MSB:0] <= next_index(byte_index);
         end
      end
   end

   assign timer_prescale_out = timer_prescale_value;

   ////////////////////////////////////////////////////////////////////////
   // acceptance filter
   // layout per object format
   function automatic logic [28:0] unpack_id(input logic [7:0] b1,
                                              input logic [7:0] b2,
                                              input logic [7:0] b3,
                                              input logic [7:0] b4,
                                              input logic       ext);
      // tag byte 4 id bits at 7..3
      return ext ? {b1, b2, b3, b4[7:3]} : {18'h0, b1, b2[7:5]};
   endfunction

   logic [NUM_OBJ-1:0] next_hit;
   always_comb begin
      logic [28:0] t_id;
      logic [28:0] m_id;
      logic [7:0]  t4;
      logic [7:0]  m4;
      logic        ext;
      logic        id_ok;
      logic        rtr_ok;
      logic        ide_ok;
      logic        rb_ok;
      t_id = '0;
      m_id = '0;
      t4 = 8'h00;
      m4 = 8'h00;
      ext = 1'b0;
      id_ok = 1'b0;
      rtr_ok = 1'b0;
      ide_ok = 1'b0;
      rb_ok = 1'b0;
      next_hit = '0;
      for (int i = 0; i < NUM_OBJ; i++) begin
         ext  = obj_ext_in[i];
         t4   = tag_mem[i][3];
         m4   = msk_mem[i][3];
         t_id = unpack_id(tag_mem[i][0], tag_mem[i][1], tag_mem[i][2],
                          t4, ext);
         m_id = unpack_id(msk_mem[i][0], msk_mem[i][1], msk_mem[i][2],
                          m4, ext);
         id_ok = ((rx_frame_in.ident ^ t_id) & m_id) == 29'h0;
         // rtr mask bit 2, ide mask bit 0
         rtr_ok = !m4[`CAFM_B4_RTR_BIT] ||
                  (rx_frame_in.rtr == t4[`CAFM_B4_RTR_BIT]);
         ide_ok = !m4[`CAFM_B4_IDE_BIT] || (rx_frame_in.ide == ext);
         // reserved tags: rb1 only for objects set to 29-bit ids
         rb_ok = (rx_frame_in.rb0 == t4[`CAFM_B4_IDE_BIT]) &&
                 (!ext || rx_frame_in.rb1 == t4[`CAFM_B4_RB1_BIT]);
         next_hit[i] = rx_frame_in.valid && obj_rx_en_in[i] &&
                       id_ok && rtr_ok && ide_ok && rb_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit side reads storage directly, no mask involvement
   wire logic tx_ok = 32'(tx_obj_in) < NUM_OBJ;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         hit_q     <= '0;
         tx_byte_q <= 8'h00;
         tx_tag4_q <= 8'h00;
      end else begin
         hit_q     <= next_hit;
         tx_byte_q <= tx_ok ? mbox[tx_obj_in][tx_byte_in] : 8'h00;
         tx_tag4_q <= tx_ok ? tag_mem[tx_obj_in][3] : 8'h00;
      end
   end

   assign rx_hit_out  = hit_q;
   assign tx_byte_out = tx_byte_q;
   assign tx_tag4_out = tx_tag4_q;

endmodule

//--- verif/cafm_filter_mailbox_sva.sv
`timescale 1ns/1ps
`include "cafm_defines.svh"
module cafm_checker
   import cafm_pkg::*;
#(
   parameter int NUM_OBJ = 15
) (
   input wire logic               mclk_in,            // clock
   input wire logic               rst_n_in,           // reset
   input wire cafm_sfr_req_t      sfr_in,             // request
   input wire logic [7:0]         sfr_rdata_out,      // read data
   input wire cafm_frame_t        rx_frame_in,        // frame
   input wire logic [NUM_OBJ-1:0] obj_rx_en_in,       // armed
   input wire logic [NUM_OBJ-1:0] obj_ext_in,         // format
   input wire logic [NUM_OBJ-1:0] rx_hit_out,         // hits
   input wire logic [3:0]         tx_obj_in,          // tx object
   input wire logic [2:0]         tx_byte_in,         // tx byte
   input wire logic [7:0]         tx_byte_out,        // tx data
   input wire logic [7:0]         tx_tag4_out,        // tx tag
   input wire logic [7:0]         timer_prescale_out  // prescaler
);
default clocking cb @(posedge mclk_in); endclocking
default disable iff (!rst_n_in);
wire rd_psc = sfr_in.rd && sfr_in.addr == `CAFM_ADDR_TPRESC;
wire wr_psc = sfr_in.wr && sfr_in.addr == `CAFM_ADDR_TPRESC;
a_rdata_idle:
   assert property (!sfr_in.rd |=> sfr_rdata_out == 8'h00)
   else $error("read data not idle");
a_presc_read:
   assert property (rd_psc |=> sfr_rdata_out == timer_prescale_out)
   else $error("prescaler read wrong");
a_presc_write:
   assert property (wr_psc |=> timer_prescale_out == $past(sfr_in.wdata))
   else $error("prescaler write lost");
a_presc_hold:
   assert property (!wr_psc |=> $stable(timer_prescale_out))
   else $error("prescaler changed");
a_presc_reset:
   assert property ($rose(rst_n_in) |-> timer_prescale_out == 8'h00)
   else $error("prescaler not zero");
a_hit_idle:
   assert property (!rx_frame_in.valid |=> rx_hit_out == '0)
   else $error("hit without frame");
a_hit_armed:
   assert property (rx_frame_in.valid
      |=> (rx_hit_out & ~$past(obj_rx_en_in)) == '0)
   else $error("hit on idle object");
a_unmapped_read:
   assert property (sfr_in.rd && sfr_in.addr == 8'h00
      |=> sfr_rdata_out == 8'h00)
   else $error("unmapped read not zero");
c_hit: cover property (rx_hit_out != '0);
c_win_rd: cover property (sfr_in.rd && sfr_in.addr == `CAFM_ADDR_MSGWIN);
c_page_wr: cover property (sfr_in.wr && sfr_in.addr == `CAFM_ADDR_PAGE);
endmodule
bind cafm_filter_mailbox cafm_checker #(.NUM_OBJ(NUM_OBJ)) i_cafm_checker (
   .mclk_in(mclk_in), .rst_n_in(rst_n_in), .sfr_in(sfr_in),
   .sfr_rdata_out(sfr_rdata_out), .rx_frame_in(rx_frame_in),
   .obj_rx_en_in(obj_rx_en_in), .obj_ext_in(obj_ext_in),
   .rx_hit_out(rx_hit_out), .tx_obj_in(tx_obj_in), .tx_byte_in(tx_byte_in),
   .tx_byte_out(tx_byte_out), .tx_tag4_out(tx_tag4_out),
   .timer_prescale_out(timer_prescale_out));

//--- verif/cafm_can_node.sv
`timescale 1ns/1ps
module cafm_can_node
   import cafm_pkg::*;
(
   input wire logic mclk_in,   // clock
   output cafm_frame_t frame_out // header to filter
);
initial frame_out = '0;
task automatic send(input logic [3:0] fl, input logic [28:0] id);
   @(negedge mclk_in);
   frame_out = {1'b1, fl, id};
   @(negedge mclk_in);
   // header gone: show inverted bits, not a stale copy
   frame_out = {1'b0, ~fl, ~id};
endtask
endmodule

//--- verif/cafm_filter_mailbox_tb_top.sv
`timescale 1ns/1ps
`include "cafm_defines.svh"
module cafm_filter_mailbox_tb_top import cafm_pkg::*; ;
localparam logic [28:0] ext_id = 29'h1ABCDEF5;
localparam logic [10:0] std_id = 11'h5A3;
logic          mclk_in = 1'b0;
logic          rst_n_in = 1'b0;
cafm_sfr_req_t sfr_in = '0;
cafm_frame_t   rx_frame;
logic [14:0]   rx_en = '0, ext = '0, hit;
logic [3:0]    tx_obj = '0;
logic [2:0]    tx_byte = '0;
logic [7:0]    rdata, tx_b, tx_t4, presc;
int            miscompares = 0, n_tests = 0, cyc = 0;
always #10 mclk_in = ~mclk_in;
cafm_filter_mailbox #(.NUM_OBJ(15)) i_cafm_filter_mailbox (
   .mclk_in(mclk_in), .rst_n_in(rst_n_in), .sfr_in(sfr_in),
   .sfr_rdata_out(rdata), .rx_frame_in(rx_frame), .obj_rx_en_in(rx_en),
   .obj_ext_in(ext), .rx_hit_out(hit), .tx_obj_in(tx_obj),
   .tx_byte_in(tx_byte), .tx_byte_out(tx_b), .tx_tag4_out(tx_t4),
   .timer_prescale_out(presc));
cafm_can_node i_cafm_can_node (.mclk_in(mclk_in), .frame_out(rx_frame));
task automatic tally_and_finish;
   $display("tests %0d mismatches %0d", n_tests, miscompares);
   if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
   end else begin
      $display("verification failed");
   end
   $finish;
endtask
task automatic chk8(input logic [7:0] got, exp);
   n_tests++;
   if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: byte %h not %h", $time, got, exp);
   end
endtask
task automatic chkh(input logic [14:0] got, exp);
   n_tests++;
   if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: hits %h not %h", $time, got, exp);
   end
endtask
// request held high across cycles counts as back-to-back pulses
task automatic req(input logic w, r, input logic [7:0] a, d);
   sfr_in = {w, r, a, d};
   @(negedge mclk_in);
endtask
task automatic rd(input logic [7:0] a, exp);
   req(1'b0, 1'b1, a, 8'h00);
   chk8(rdata, exp);
endtask
task automatic fr(input logic [3:0] fl, input logic [28:0] id,
                  input logic [14:0] exp);
   i_cafm_can_node.send(fl, id);
   chkh(hit, exp);
endtask
task automatic prog(input logic [3:0] o, input logic [31:0] t, m);
   req(1'b1, 1'b0, `CAFM_ADDR_PAGE, {o, 4'h0});
   for (int i = 0; i < 4; i++) begin
      req(1'b1, 1'b0, 8'(`CAFM_ADDR_TAG1 + i), t[31-8*i -: 8]);
   end
   for (int i = 0; i < 4; i++) begin
      req(1'b1, 1'b0, 8'(`CAFM_ADDR_MSK1 + i), m[31-8*i -: 8]);
   end
endtask
task automatic t_presc;
   rd(`CAFM_ADDR_TPRESC, 8'h00);
   req(1'b1, 1'b0, `CAFM_ADDR_TPRESC, 8'hFF);
   rd(`CAFM_ADDR_TPRESC, 8'hFF);
   req(1'b1, 1'b0, 8'h00, 8'h5A);
   rd(8'h00, 8'h00);
   chk8(presc, 8'hFF);
endtask
task automatic t_window;
   req(1'b1, 1'b0, `CAFM_ADDR_PAGE, 8'h28);
   for (int i = 0; i < 9; i++) begin
      req(1'b1, 1'b0, `CAFM_ADDR_MSGWIN, 8'(8'h10 + i));
   end
   req(1'b1, 1'b0, `CAFM_ADDR_PAGE, 8'h28);
   for (int i = 0; i < 8; i++) begin
      rd(`CAFM_ADDR_MSGWIN, (i == 0) ? 8'h18 : 8'(8'h10 + i));
   end
   req(1'b1, 1'b0, `CAFM_ADDR_PAGE, 8'h2D);
   rd(`CAFM_ADDR_MSGWIN, 8'h15);
   rd(`CAFM_ADDR_MSGWIN, 8'h16);
   req(1'b1, 1'b0, `CAFM_ADDR_PAGE, 8'h25);
   rd(`CAFM_ADDR_MSGWIN, 8'h15);
   rd(`CAFM_ADDR_MSGWIN, 8'h15);
   req(1'b0, 1'b0, 8'h00, 8'h00);
   tx_obj = 4'h2;
   tx_byte = 3'h3;
   repeat (2) @(negedge mclk_in);
   chk8(tx_b, 8'h13);
endtask
task automatic t_filter;
   prog(4'h1, {ext_id, 3'b010}, {29'h1FFFFFF0, 3'b101});
   rd(`CAFM_ADDR_TAG4, 8'hAA);
   rd(`CAFM_ADDR_MSK4, 8'h85);
   prog(4'h3, {std_id, 21'h0}, {11'h7FF, 18'h0, 3'b101});
   rd(`CAFM_ADDR_MSK2, 8'hE0);
   req(1'b0, 1'b0, 8'h00, 8'h00);
   ext = 15'h0002;
   rx_en = 15'h000A;
   tx_obj = 4'h1;
   fr(4'b1010, ext_id, 15'h0002);
   chk8(tx_t4, 8'hAA);
   fr(4'b1010, ext_id ^ 29'h0000000F, 15'h0002);
   fr(4'b1010, ext_id ^ 29'h00000010, 15'h0000);
   fr(4'b1110, ext_id, 15'h0000);
   fr(4'b0000, {18'h0, std_id}, 15'h0008);
   fr(4'b0000, {18'h3FFFF, std_id}, 15'h0008);
   fr(4'b0000, {18'h0, std_id ^ 11'h001}, 15'h0000);
   rx_en = 15'h0000;
   fr(4'b1010, ext_id, 15'h0000);
endtask
initial begin
   repeat (8) @(negedge mclk_in);
   rst_n_in = 1'b1;
   t_presc();
   t_window();
   t_filter();
   tally_and_finish();
end
always @(posedge mclk_in) begin
   cyc <= cyc + 1;
   if (cyc == 2000) begin
      miscompares++;
      tally_and_finish();
   end
end
endmodule
